// *** sar_responder.sv ***
// abort-code responder and emergency producer for object-dictionary access
`default_nettype none
module sar_responder
  import sar_pkg::*;
#(
  parameter int unsigned SEG_TIMEOUT_CYC = 32'(SEG_TIMEOUT_CYC_D)
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // request from the master, with dictionary checks for it
  input  wire logic               req_valid,
  input  wire logic [FRAME_W-1:0] req_data,
  input  wire logic [NFLT-1:0]    od_fault,
  input  wire logic               app_ul_end,
  // abort answer and pass-through of good requests
  output var  logic               resp_valid,
  output var  logic [FRAME_W-1:0] resp_data,
  output var  logic               req_accept,
  output var  logic               seg_busy,
  // exception sources and emergency message
  input  wire logic               exc_valid,
  input  wire logic               exc_comm,
  input  wire logic [15:0]        exc_code,
  output var  logic               emcy_valid,
  output var  logic [FRAME_W-1:0] emcy_data
);

  sar_chk_if chk ();

  sar_state_e       state;
  sar_state_e       next_state;
  logic             tog;
  logic             next_tog;
  logic [15:0]      idx_save;
  logic [7:0]       sub_save;
  logic [TMO_W-1:0] tmo_cnt;
  logic             next_abort;
  logic [31:0]      next_code;
  logic             next_accept;
  logic             next_use_save;
  logic             tmo_hit;

  wire logic [2:0]  cs      = req_data[CS_LSB +: 3];
  wire logic        is_init = (cs == CS_INIT_DL) || (cs == CS_INIT_UL);

  assign chk.fault    = od_fault;
  assign chk.is_write = (cs == CS_INIT_DL);

  sar_code_select u_sel (
    .chk (chk)
  );

  // watchdog expiry only matters while a segmented transfer is open
  assign tmo_hit = (state != ST_IDLE) && (tmo_cnt == TMO_W'(SEG_TIMEOUT_CYC - 1));

  // request decode; a request in the expiry cycle wins over the watchdog
  always_comb begin
    next_state    = state;
    next_tog      = tog;
    next_abort    = 1'b0;
    next_code     = '0;
    next_accept   = 1'b0;
    next_use_save = 1'b0;
    if (req_valid) begin
      unique case (cs)
        CS_ABORT: begin
          next_state = ST_IDLE;
        end
        CS_INIT_DL, CS_INIT_UL: begin
          if (chk.hit) begin
            next_abort = 1'b1;
            next_code  = chk.code;
            next_state = ST_IDLE;
          end else begin
            next_accept = 1'b1;
            next_tog    = 1'b0;
            if (cs == CS_INIT_DL) begin
              next_state = req_data[EXP_BIT] ? ST_IDLE : ST_SEG_DL;
            end else begin
              next_state = od_fault[F_GEN_ERR] ? ST_IDLE : ST_SEG_UL;
            end
          end
        end
        CS_DL_SEG, CS_UL_SEG: begin
          next_use_save = 1'b1;
          if ((cs == CS_DL_SEG && state != ST_SEG_DL) ||
              (cs == CS_UL_SEG && state != ST_SEG_UL)) begin
            next_abort = 1'b1;
            next_code  = AB_BAD_CS;
            next_state = ST_IDLE;
          end else if (req_data[TOG_BIT] != tog) begin
            next_abort = 1'b1;
            next_code  = AB_TOGGLE;
            next_state = ST_IDLE;
          end else begin
            next_accept = 1'b1;
            next_tog    = ~tog;
            if (cs == CS_DL_SEG && req_data[LAST_BIT]) begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_abort = 1'b1;
          next_code  = AB_BAD_CS;
          next_state = ST_IDLE;
        end
      endcase
    end else if (tmo_hit) begin
      next_abort    = 1'b1;
      next_code     = AB_TIMEOUT;
      next_use_save = 1'b1;
      next_state    = ST_IDLE;
    end else if (app_ul_end && state == ST_SEG_UL) begin
      next_state = ST_IDLE;
    end
  end

  // transfer state; any abort returns to idle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      tog   <= 1'b0;
    end else begin
      state <= next_state;
      tog   <= next_tog;
    end
  end

  // segment frames carry no index, so the initiating one is kept
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idx_save <= '0;
      sub_save <= '0;
    end else if (req_valid && is_init) begin
      idx_save <= req_data[IDX_LSB +: 16];
      sub_save <= req_data[SUB_LSB +: 8];
    end
  end

  // watchdog restarts on every request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tmo_cnt <= '0;
    end else if (req_valid || state == ST_IDLE || tmo_hit) begin
      tmo_cnt <= '0;
    end else begin
      tmo_cnt <= tmo_cnt + TMO_W'(1);
    end
  end

  // abort frame; code bytes low first simply by bit order
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_data  <= '0;
      req_accept <= 1'b0;
      seg_busy   <= 1'b0;
    end else begin
      resp_valid <= next_abort;
      req_accept <= next_accept;
      seg_busy   <= (next_state != ST_IDLE);
      if (next_abort) begin
        resp_data <= {next_code,
                      next_use_save ? sub_save : req_data[SUB_LSB +: 8],
                      next_use_save ? idx_save : req_data[IDX_LSB +: 16],
                      ABORT_BYTE0};
      end
    end
  end

  // emergency frame: error code low byte first, then error register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      emcy_valid <= 1'b0;
      emcy_data  <= '0;
    end else begin
      emcy_valid <= exc_valid;
      if (exc_valid) begin
        emcy_data <= {40'h0, exc_comm ? EMCY_REG_COMM : EMCY_REG_DRIVE, exc_code};
      end
    end
  end

  // checks on the answers
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_rx_abort;
    req_valid && cs == CS_ABORT;
  endsequence

  sequence s_bad_toggle;
    req_valid && cs == CS_DL_SEG && state == ST_SEG_DL && req_data[TOG_BIT] != tog;
  endsequence

  a_abort_frame_head: assert property (resp_valid |-> resp_data[7:0] == ABORT_BYTE0)
    else $error("abort frame specifier wrong");

  a_init_echo_code: assert property (req_valid && is_init && chk.hit |=>
      resp_valid && resp_data[IDX_LSB +: 24] == $past(req_data[IDX_LSB +: 24])
      && resp_data[CODE_LSB +: 32] == $past(chk.code))
    else $error("abort does not echo index or code");

  a_toggle_abort: assert property (s_bad_toggle |=>
      resp_valid && resp_data[CODE_LSB +: 32] == AB_TOGGLE && state == ST_IDLE)
    else $error("toggle error not aborted");

  a_timeout_abort: assert property (tmo_hit && !req_valid |=>
      resp_valid && resp_data[CODE_LSB +: 32] == AB_TIMEOUT && !seg_busy)
    else $error("timeout not aborted");

  a_bad_spec: assert property (req_valid && cs > CS_ABORT |=>
      resp_valid && resp_data[CODE_LSB +: 32] == AB_BAD_CS)
    else $error("unknown specifier not aborted");

  a_emcy_out: assert property (exc_valid |=> emcy_valid &&
      emcy_data[15:0] == $past(exc_code))
    else $error("emergency message missing");

  a_index_missing: assert property (req_valid && is_init && od_fault[F_IDX_MISSING] |=>
      resp_data[CODE_LSB +: 32] == 32'h06020000)
    else $error("missing index code wrong");

  a_sub_missing: assert property (req_valid && is_init && od_fault[1:0] == 2'h2 |=>
      resp_data[CODE_LSB +: 32] == 32'h06090011)
    else $error("missing subindex code wrong");

  a_write_fault: assert property (req_valid && cs == CS_INIT_DL &&
      od_fault[F_LEN_LONG:0] == 6'h20 |=> resp_data[CODE_LSB +: 32] == 32'h06070012)
    else $error("length too long code wrong");

  a_read_ignores_wr: assert property (req_valid && cs == CS_INIT_UL &&
      (od_fault & ~WR_MASK) == '0 |=> !resp_valid && req_accept)
    else $error("write-side check raised on read");

  a_rx_abort_clear: assert property (s_rx_abort |=> !seg_busy && !resp_valid)
    else $error("received abort left transfer open");

endmodule
`default_nettype wire

// *** sar_pkg.sv ***
// constants, codes and types shared by the abort-code responder
`default_nettype none
package sar_pkg;

  // clock and segmented-transfer watchdog
  localparam longint unsigned CLK_HZ            = 64'd40000000;
  localparam longint unsigned SEG_TIMEOUT_MS    = 64'd1000;
  localparam longint unsigned SEG_TIMEOUT_CYC_D = (SEG_TIMEOUT_MS * CLK_HZ) / 64'd1000;
  localparam int              TMO_W             = 32;

  // frame layout: byte 0 sits in bits 7:0
  localparam int FRAME_W   = 64;
  localparam int CS_LSB    = 5;
  localparam int TOG_BIT   = 4;
  localparam int EXP_BIT   = 1;
  localparam int LAST_BIT  = 0;
  localparam int IDX_LSB   = 8;
  localparam int SUB_LSB   = 24;
  localparam int CODE_LSB  = 32;

  // command specifiers (3 bits)
  localparam logic [2:0] CS_DL_SEG  = 3'h0;
  localparam logic [2:0] CS_INIT_DL = 3'h1;
  localparam logic [2:0] CS_INIT_UL = 3'h2;
  localparam logic [2:0] CS_UL_SEG  = 3'h3;
  localparam logic [2:0] CS_ABORT   = 3'h4;
  localparam logic [7:0] ABORT_BYTE0 = 8'h80;

  // abort codes raised by the responder itself
  localparam logic [31:0] AB_TOGGLE  = 32'h05030000;
  localparam logic [31:0] AB_TIMEOUT = 32'h05040000;
  localparam logic [31:0] AB_BAD_CS  = 32'h05040001;

  // object-dictionary fault vector, lower bit has priority
  localparam int F_IDX_MISSING  = 0;
  localparam int F_SUB_MISSING  = 1;
  localparam int F_NO_ACCESS    = 2;
  localparam int F_WRITE_ONLY   = 3;
  localparam int F_READ_ONLY    = 4;
  localparam int F_LEN_LONG     = 5;
  localparam int F_LEN_SHORT    = 6;
  localparam int F_OUT_RANGE    = 7;
  localparam int F_TOO_HIGH     = 8;
  localparam int F_TOO_LOW      = 9;
  localparam int F_MAX_LT_MIN   = 10;
  localparam int F_NOT_MAPPABLE = 11;
  localparam int F_MAP_TOO_LONG = 12;
  localparam int F_MEM_OVF      = 13;
  localparam int F_APP_FAIL     = 14;
  localparam int F_LOCAL_CTL    = 15;
  localparam int F_GEN_ERR      = 16;
  localparam int NFLT           = 17;

  // faults that only count on a write, or only on a read
  localparam logic [NFLT-1:0] WR_MASK = 17'h01ff0;
  localparam logic [NFLT-1:0] RD_MASK = 17'h00008;

  localparam logic [31:0] FLT_CODE [NFLT] = '{
    32'h06020000,
    32'h06090011,
    32'h06010000, 32'h06010001, 32'h06010002,
    32'h06070012, 32'h06070013,
    32'h06090030, 32'h06090031, 32'h06090032,
    32'h06090036,
    32'h06040041, 32'h06040042,
    32'h05040005,
    32'h08000020, 32'h08000021, 32'h08000000};

  // emergency error-register byte
  localparam logic [7:0] EMCY_REG_COMM  = 8'h10;
  localparam logic [7:0] EMCY_REG_DRIVE = 8'h01;

  typedef enum logic [1:0] {ST_IDLE, ST_SEG_DL, ST_SEG_UL} sar_state_e;

endpackage
`default_nettype wire

// *** sar_chk_if.sv ***
// carrier between the responder and its fault-code selector
`default_nettype none
interface sar_chk_if;
  import sar_pkg::*;
  logic [NFLT-1:0] fault;
  logic            is_write;
  logic            hit;
  logic [31:0]     code;
  modport src (output fault, output is_write, input hit, input code);
  modport sel (input fault, input is_write, output hit, output code);
endinterface
`default_nettype wire

// *** sar_code_select.sv ***
// priority selector from object-dictionary faults to an abort code
`default_nettype none
module sar_code_select
  import sar_pkg::*;
(
  // fault flags in, code out
  sar_chk_if.sel chk
);

  logic [NFLT-1:0] eff;

  // direction-dependent faults are dropped for the other direction
  always_comb begin
    eff = chk.fault & ~(chk.is_write ? RD_MASK : WR_MASK);
    chk.hit = |eff;
    chk.code = '0;
    // walk downward so the lowest set bit is left standing
    for (int i = NFLT - 1; i >= 0; i--) begin
      if (eff[i]) begin
        chk.code = FLT_CODE[i];
      end
    end
  end

endmodule
`default_nettype wire

// *** sar_fb_master.sv ***
// fieldbus master model issuing dictionary requests to the responder
`default_nettype none
module sar_fb_master
  import sar_pkg::*;
(
  // clock
  input  wire logic               clk_sys,
  // request side
  output var  logic               req_valid,
  output var  logic [FRAME_W-1:0] req_data,
  output var  logic [NFLT-1:0]    od_fault,
  // answer side
  input  wire logic               resp_valid,
  input  wire logic               req_accept
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog; // toggle the responder expects on the next segment
  initial begin
    req_valid = 1'b0;
    req_data  = '0;
    od_fault  = '0;
    tog       = 1'b0;
  end
  // one request, answer sampled 1 ns after the edge that takes it
  task automatic send(input logic [FRAME_W-1:0] f, input logic [NFLT-1:0] flt,
                      output logic rv, output logic acc);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_data  <= f;
    od_fault  <= flt;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    req_data  <= ~f;   // released lines never keep the stale frame
    od_fault  <= ~flt;
    #1;
    rv  = resp_valid;
    acc = req_accept;
    // any abort or new initiate drops our segment state
    if (rv || f[7:5] == CS_ABORT || f[7:5] == CS_INIT_DL || f[7:5] == CS_INIT_UL) begin
      tog = 1'b0;
    end else if (acc && (f[7:5] == CS_DL_SEG || f[7:5] == CS_UL_SEG)) begin
      tog = ~tog;
    end
  endtask
endmodule
`default_nettype wire

// *** sdo_abort_code_responder_tb.sv ***
// self-checking bench for the abort-code responder
`default_nettype none
module sdo_abort_code_responder_tb;
  import sar_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TMO = 20; // short watchdog for simulation
  logic               clk_sys, rst, req_valid, app_ul_end, resp_valid;
  logic               req_accept, seg_busy, exc_valid, exc_comm, emcy_valid, rv, acc;
  logic [FRAME_W-1:0] req_data, resp_data, emcy_data;
  logic [NFLT-1:0]    od_fault;
  logic [15:0]        exc_code;
  int                 err_count, tests_run;
  logic [31:0]        codes [NFLT] = '{32'h06020000, 32'h06090011, 32'h06010000,
    32'h06010001, 32'h06010002, 32'h06070012, 32'h06070013, 32'h06090030, 32'h06090031,
    32'h06090032, 32'h06090036, 32'h06040041, 32'h06040042, 32'h05040005, 32'h08000020,
    32'h08000021, 32'h08000000};

  sar_responder #(.SEG_TIMEOUT_CYC(TMO)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .req_valid(req_valid), .req_data(req_data), .od_fault(od_fault),
    .app_ul_end(app_ul_end), .resp_valid(resp_valid), .resp_data(resp_data),
    .req_accept(req_accept), .seg_busy(seg_busy), .exc_valid(exc_valid),
    .exc_comm(exc_comm), .exc_code(exc_code), .emcy_valid(emcy_valid),
    .emcy_data(emcy_data));
  sar_fb_master u_m (.clk_sys(clk_sys), .req_valid(req_valid), .req_data(req_data),
    .od_fault(od_fault), .resp_valid(resp_valid), .req_accept(req_accept));

  // comparisons
  task automatic chk_frame(input logic [FRAME_W-1:0] got, input logic [FRAME_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_frame({63'h0, got}, {63'h0, exp});
  endtask
  // request frame: specifier, toggle, expedited flag, index, subindex
  function automatic logic [FRAME_W-1:0] fr(input logic [2:0] cs, input logic t,
                                            input logic e, input logic [15:0] idx,
                                            input logic [7:0] sub);
    return {32'h0, sub, idx, cs, t, 2'b00, e, 1'b0};
  endfunction

  task automatic t_fault_codes();
    for (int i = 0; i < NFLT; i++) begin
      u_m.send(fr(i == 3 ? CS_INIT_UL : CS_INIT_DL, 1'b0, 1'b1, 16'h1000 + 16'(i),
               8'(i)), NFLT'(1) << i, rv, acc);
      chk_bit(rv, 1'b1);
      chk_frame(resp_data, {codes[i], 8'(i), 16'h1000 + 16'(i), 8'h80});
    end
    // write-only flag is meaningless on a download
    u_m.send(fr(CS_INIT_DL, 1'b0, 1'b1, 16'h2222, 8'h01), 17'h00008, rv, acc);
    chk_bit(acc, 1'b1);
    // write-side flags are meaningless on an upload, which then opens
    u_m.send(fr(CS_INIT_UL, 1'b0, 1'b0, 16'h2224, 8'h03), 17'h01ff0, rv, acc);
    chk_bit(acc & seg_busy, 1'b1);
    // lowest flag wins when several are raised; the abort closes the upload
    u_m.send(fr(CS_INIT_DL, 1'b0, 1'b1, 16'h2223, 8'h02), 17'h10001, rv, acc);
    chk_frame(resp_data, {32'h06020000, 8'h02, 16'h2223, 8'h80});
    chk_bit(seg_busy, 1'b0);
  endtask

  task automatic t_bad_cs();
    for (int c = 5; c < 9; c++) begin
      u_m.send(fr(3'(c), 1'b0, 1'b0, 16'h3000, 8'h00), '0, rv, acc);
      chk_frame({32'h0, resp_data[63:32]}, {32'h0, 32'h05040001});
    end
    // upload opens, application ends it
    u_m.send(fr(CS_INIT_UL, 1'b0, 1'b0, 16'h3001, 8'h00), '0, rv, acc);
    chk_bit(acc, 1'b1);
    chk_bit(seg_busy, 1'b1);
    // one upload segment with the expected toggle
    u_m.send(fr(CS_UL_SEG, u_m.tog, 1'b0, 16'h0, 8'h0), '0, rv, acc);
    chk_bit(acc, 1'b1);
    @(posedge clk_sys);
    app_ul_end <= 1'b1;
    @(posedge clk_sys);
    app_ul_end <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_bit(seg_busy, 1'b0);
  endtask

  task automatic t_toggle(input logic rx_abort);
    u_m.send(fr(CS_INIT_DL, 1'b0, 1'b0, 16'h4000, 8'h03), '0, rv, acc);
    u_m.send(fr(CS_DL_SEG, u_m.tog, 1'b0, 16'h0, 8'h0), '0, rv, acc);
    chk_bit(acc, 1'b1);
    if (rx_abort) begin
      u_m.send(fr(CS_ABORT, 1'b0, 1'b0, 16'h4000, 8'h03), '0, rv, acc);
      chk_bit(rv | acc, 1'b0);
    end else begin
      u_m.send(fr(CS_DL_SEG, ~u_m.tog, 1'b0, 16'h0, 8'h0), '0, rv, acc);
      chk_frame(resp_data, {32'h05030000, 8'h03, 16'h4000, 8'h80});
    end
    // transfer is gone, a segment now is out of place
    u_m.send(fr(CS_DL_SEG, u_m.tog, 1'b0, 16'h0, 8'h0), '0, rv, acc);
    chk_frame({32'h0, resp_data[63:32]}, {32'h0, 32'h05040001});
  endtask

  task automatic t_timeout();
    int n;
    u_m.send(fr(CS_INIT_DL, 1'b0, 1'b0, 16'h5000, 8'h04), '0, rv, acc);
    n = 0;
    while (resp_valid !== 1'b1 && n < 3 * TMO) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk_frame(64'(n), 64'(TMO));
    chk_frame(resp_data, {32'h05040000, 8'h04, 16'h5000, 8'h80});
  endtask

  task automatic t_emcy();
    for (int c = 0; c < 2; c++) begin
      @(posedge clk_sys);
      exc_valid <= 1'b1;
      exc_comm  <= c[0];
      exc_code  <= 16'h8a31 + 16'(c);
      @(posedge clk_sys);
      exc_valid <= 1'b0;
      #1;
      chk_bit(emcy_valid, 1'b1);
      chk_frame(emcy_data, {40'h0, c[0] ? 8'h10 : 8'h01, 16'h8a31 + 16'(c)});
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // watchdog, far beyond the hundred or so cycles the run needs
  initial begin
    #(25 * 5000);
    err_count++;
    tally_and_finish();
  end
  initial begin
    rst        = 1'b1;
    app_ul_end = 1'b0;
    exc_valid  = 1'b0;
    exc_comm   = 1'b0;
    exc_code   = '0;
    err_count  = 0;
    tests_run  = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk_frame({resp_data[62:0], resp_valid}, '0);
    chk_bit(resp_data[63] | req_accept | seg_busy | emcy_valid | (|emcy_data), 1'b0);
    t_fault_codes();
    t_bad_cs();
    t_toggle(1'b0);
    t_toggle(1'b1);
    t_timeout();
    t_emcy();
    tally_and_finish();
  end
endmodule
`default_nettype wire
